// ==== common/adc_seq_pkg.sv ====
// constants for the dual-trigger converter sequencer: register offsets,
// field positions, reset values and state encoding.
// assumes an 8-bit register port with a 5-bit word address.
package adc_seq_pkg;

    localparam int ADDR_W = 5;
    localparam int DATA_W = 8;

    // register offsets
    localparam logic [4:0] OFF_CTRL0    = 5'h00;
    localparam logic [4:0] OFF_CTRL1    = 5'h01;
    localparam logic [4:0] OFF_CTRL2    = 5'h02;
    localparam logic [4:0] OFF_DELAY    = 5'h03;
    localparam logic [4:0] OFF_SLOTG1   = 5'h04;
    localparam logic [4:0] OFF_SLOTG2   = 5'h05;
    localparam logic [4:0] OFF_IRQFLAG  = 5'h06;
    localparam logic [4:0] OFF_SRES_HI  = 5'h07;
    localparam logic [4:0] OFF_SRES_LO  = 5'h08;
    localparam logic [4:0] OFF_SCAN_RES = 5'h09;  // slot n: high at +2n, low at +2n+1

    // converter_control_0 fields
    localparam int C0_START   = 7;
    localparam int C0_BUSY    = 6;
    localparam int C0_PWROFF  = 5;
    localparam int C0_FORMAT  = 4;
    localparam int C0_CHAN_LO = 0;
    // converter_control_1 fields
    localparam int C1_SCAN_EN = 7;
    localparam int C1_SRC_SEL = 6;
    localparam int C1_DIV_LO  = 0;
    // converter_control_2 fields
    localparam int C2_RES_SEL = 7;
    localparam int C2_DONE    = 6;
    localparam int C2_INVALID = 5;
    localparam int C2_DUTY_LO = 2;
    localparam int C2_CNT_LO  = 0;
    // irq flag register fields
    localparam int IRQ_SINGLE = 0;
    localparam int IRQ_SCAN   = 1;

    // reset values
    localparam logic [7:0] RST_CTRL0 = 8'h20;  // converter powered off
    localparam logic [7:0] RST_CTRL1 = 8'h00;
    localparam logic [7:0] RST_CTRL2 = 8'h00;
    localparam logic [7:0] RST_DELAY = 8'h00;
    localparam logic [7:0] RST_SLOTG = 8'h00;

    // scan geometry and converter widths
    localparam int SLOTS     = 4;
    localparam int CONV_W    = 12;
    localparam logic [2:0] DIV_UNDEF = 3'h7;
    localparam logic [11:0] FULL12 = 12'hFFF;
    localparam logic [11:0] FULL10 = 12'h3FF;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SOFT_CONV,
        ST_SCAN_DELAY,
        ST_SCAN_CONV
    } seq_state_type;

endpackage : adc_seq_pkg

// ==== tb/adc_dual_trigger_sequencer_tb.sv ====
// self-checking bench for the converter sequencer.
// assumes the core model answers each start after LAT cycles.
`timescale 1ns/10ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin failures++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); end end
module adc_dual_trigger_sequencer_tb;
    localparam int LAT = 6;
    logic        clk = 1'b0, sysRst = 1'b1, regWrite = 1'b0, regRead = 1'b0;
    logic [4:0]  regAddr = 5'h00;
    logic [7:0]  regWrData = 8'h00, regRdData;
    logic        pwmPeriodIrq = 1'b0;
    logic [3:0]  pwmDutyIrq = 4'h0, convChannel;
    logic        convStart, convAbort, convPowerOff, convRes10, convClkTick, convDone;
    logic [11:0] convData;
    logic        singleIrqReq, scanIrqReq;
    int          failures = 0, check_count = 0, cyc = 0, starts = 0, aborts = 0, ticks = 0;
    adc_dual_trigger_sequencer uut (.clk(clk), .sys_rst(sysRst), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .pwmPeriodIrq(pwmPeriodIrq), .pwmDutyIrq(pwmDutyIrq), .convStart(convStart),
        .convAbort(convAbort), .convChannel(convChannel), .convPowerOff(convPowerOff),
        .convRes10(convRes10), .convClkTick(convClkTick), .convDone(convDone),
        .convData(convData), .singleIrqReq(singleIrqReq), .scanIrqReq(scanIrqReq));
    conv_core_model #(.LAT(LAT)) core (.clk(clk), .convStart(convStart), .convAbort(convAbort),
        .convPowerOff(convPowerOff), .convRes10(convRes10), .convChannel(convChannel),
        .convDone(convDone), .convData(convData));
    initial forever #25 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        starts <= starts + int'(convStart);
        aborts <= aborts + int'(convAbort);
        ticks <= ticks + int'(convClkTick);
        if (cyc == 40000) begin
            failures++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : wrap_up
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask : wr
    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        @(posedge clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRead <= 1'b0;
        #1 `CHK(regRdData, e)
    endtask : rd
    task automatic wstart(output int n);
        n = 0;
        do begin
            @(posedge clk);
            #1 n++;
        end while (!convStart && n < 200);
    endtask : wstart
    task automatic t_scan(input logic [1:0] cnt, input logic [7:0] dly, input logic duty,
                          input logic [1:0] sel);
        logic [11:0] d;
        int          n;
        wr(adc_seq_pkg::OFF_DELAY, dly);
        wr(adc_seq_pkg::OFF_CTRL2, {4'h0, sel, cnt});
        wr(adc_seq_pkg::OFF_CTRL1, {1'b1, duty, 6'h00});
        @(posedge clk);
        pwmPeriodIrq <= !duty;
        pwmDutyIrq <= duty ? (4'h1 << sel) : 4'h0;
        n = 0;
        do begin
            @(posedge clk);
            pwmPeriodIrq <= 1'b0;
            pwmDutyIrq <= 4'h0;
            #1 n++;
            if (n == 1) `CHK(convChannel, 4'h1)
        end while (!convStart && n < 300);
        `CHK(n, dly + 1)
        for (int s = 0; s <= cnt; s++) begin
            if (s > 0) begin wstart(n); `CHK(n, LAT + 1) end
            `CHK(convChannel, 4'(s + 1))
        end
        repeat (LAT + 1) @(posedge clk);
        #1 `CHK(scanIrqReq, 1'b1)
        `CHK(convChannel, 4'hC)
        rd(adc_seq_pkg::OFF_CTRL2, {4'h4, sel, cnt});
        for (int s = 0; s <= cnt; s++) begin
            d = {4'(s + 1), 4'h5, 4'(s + 1)};
            rd(adc_seq_pkg::OFF_SCAN_RES + 5'(2 * s), {4'h0, d[11:8]});
            rd(adc_seq_pkg::OFF_SCAN_RES + 5'(2 * s + 1), d[7:0]);
        end
        wr(adc_seq_pkg::OFF_CTRL2, {4'h0, sel, cnt});
        wr(adc_seq_pkg::OFF_IRQFLAG, 8'h00);
        rd(adc_seq_pkg::OFF_CTRL2, {4'h0, sel, cnt});
    endtask : t_scan
    task automatic t_preempt();
        int n, s0;
        wr(adc_seq_pkg::OFF_CTRL2, 8'h01);
        wr(adc_seq_pkg::OFF_DELAY, 8'h02);
        wr(adc_seq_pkg::OFF_CTRL0, 8'h9C);
        wr(adc_seq_pkg::OFF_CTRL0, 8'h1C);
        wstart(n);
        @(posedge clk);
        pwmDutyIrq <= 4'h1;
        @(posedge clk);
        pwmDutyIrq <= 4'h0;
        repeat (40) @(posedge clk);
        #1 `CHK(aborts, 1)
        `CHK(scanIrqReq, 1'b1)
        `CHK(singleIrqReq, 1'b0)
        rd(adc_seq_pkg::OFF_CTRL0, 8'h1C);
        rd(adc_seq_pkg::OFF_CTRL2, 8'h61);
        s0 = starts;
        repeat (30) @(posedge clk);
        `CHK(starts, s0)
        wr(adc_seq_pkg::OFF_IRQFLAG, 8'h00);
    endtask : t_preempt
    task automatic t_soft(input logic [3:0] ch, input logic fmt, input logic res);
        logic [11:0] d;
        logic [15:0] e;
        int          n;
        d = {ch, 4'h5, ch} & (res ? 12'h3FF : 12'hFFF);
        e = res ? (fmt ? {6'h00, d[9:0]} : {d[9:0], 6'h00}) : (fmt ? {4'h0, d} : {d, 4'h0});
        wr(adc_seq_pkg::OFF_CTRL2, {res, 7'h00});
        wr(adc_seq_pkg::OFF_CTRL0, {3'h4, fmt, ch});
        wr(adc_seq_pkg::OFF_CTRL0, {3'h0, fmt, ch});
        wstart(n);
        `CHK(convChannel, ch)
        `CHK(convRes10, res)
        rd(adc_seq_pkg::OFF_CTRL0, {3'h2, fmt, ch});
        repeat (LAT - 1) @(posedge clk);
        #1 `CHK(singleIrqReq, 1'b1)
        rd(adc_seq_pkg::OFF_CTRL0, {3'h0, fmt, ch});
        rd(adc_seq_pkg::OFF_CTRL2, {res, 7'h00});
        rd(adc_seq_pkg::OFF_SRES_HI, e[15:8]);
        rd(adc_seq_pkg::OFF_SRES_LO, e[7:0]);
        wr(adc_seq_pkg::OFF_IRQFLAG, 8'h00);
        #1 `CHK(singleIrqReq, 1'b0)
    endtask : t_soft
    task automatic t_div();
        int t0;
        for (int c = 0; c < 8; c++) begin
            wr(adc_seq_pkg::OFF_CTRL1, 8'(c));
            repeat (70) @(posedge clk);
            t0 = ticks;
            repeat (64) @(posedge clk);
            `CHK(ticks - t0, (c == 7) ? 0 : 64 >> c)
        end
    endtask : t_div
    task automatic t_off();
        int t0, s0;
        wr(adc_seq_pkg::OFF_CTRL1, 8'h00);
        wr(adc_seq_pkg::OFF_CTRL0, 8'hBC);
        wr(adc_seq_pkg::OFF_CTRL0, 8'h3C);
        t0 = ticks;
        s0 = starts;
        repeat (64) @(posedge clk);
        `CHK(ticks - t0, 0)
        `CHK(starts - s0, 0)
        `CHK(convPowerOff, 1'b1)
    endtask : t_off
    initial begin
        repeat (6) @(posedge clk);
        sysRst <= 1'b0;
        rd(adc_seq_pkg::OFF_CTRL0, 8'h20);
        rd(5'h1F, 8'h00);
        wr(adc_seq_pkg::OFF_SLOTG1, 8'h21);
        wr(adc_seq_pkg::OFF_SLOTG2, 8'h43);
        wr(adc_seq_pkg::OFF_CTRL0, 8'h1C);
        t_div();
        t_scan(2'h3, 8'h05, 1'b0, 2'h0);
        for (int i = 0; i < 4; i++) t_scan(2'(i), 8'(i * 3), 1'b1, 2'(i));
        t_preempt();
        t_soft(4'h7, 1'b0, 1'b0);
        t_soft(4'h2, 1'b0, 1'b1);
        t_off();
        wrap_up();
    end
endmodule : adc_dual_trigger_sequencer_tb

// ==== tb/adc_seq_properties.sv ====
// port checker for the converter sequencer.
// assumes one clock and a synchronous reset.
`timescale 1ns/10ps
module adc_seq_properties (
    input wire logic       clk,          // clock
    input wire logic       sys_rst,      // reset
    input wire logic [4:0] regAddr,      // address
    input wire logic [7:0] regWrData,    // write data
    input wire logic       regWrite,     // write strobe
    input wire logic       convStart,    // start pulse
    input wire logic       convAbort,    // abort pulse
    input wire logic       convPowerOff, // power off
    input wire logic       convClkTick,  // divided tick
    input wire logic       convDone,     // core done
    input wire logic       singleIrqReq, // single irq
    input wire logic       scanIrqReq    // scan irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic irqWr;
    assign irqWr = regWrite && regAddr == adc_seq_pkg::OFF_IRQFLAG;
    a_start_one_cycle: assert property (convStart |=> !convStart)
        else $error("start pulse too long");
    a_abort_one_cycle: assert property (convAbort |=> !convAbort)
        else $error("abort pulse too long");
    a_off_no_start: assert property (convPowerOff && $past(convPowerOff) |-> !convStart)
        else $error("start while powered off");
    a_off_no_tick: assert property (convPowerOff && $past(convPowerOff) |-> !convClkTick)
        else $error("tick while powered off");
    a_scan_irq_kept: assert property (scanIrqReq && !(irqWr && !regWrData[1]) |=> scanIrqReq)
        else $error("scan irq dropped");
    a_single_irq_kept: assert property (singleIrqReq && !(irqWr && !regWrData[0])
        |=> singleIrqReq)
        else $error("single irq dropped");
    a_scan_irq_cause: assert property ($rose(scanIrqReq) |-> $past(convDone))
        else $error("scan irq without done");
    a_single_irq_cause: assert property ($rose(singleIrqReq) |-> $past(convDone))
        else $error("single irq without done");
endmodule : adc_seq_properties
bind adc_dual_trigger_sequencer adc_seq_properties chk (.clk(clk), .sys_rst(sys_rst),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .convStart(convStart),
    .convAbort(convAbort), .convPowerOff(convPowerOff), .convClkTick(convClkTick),
    .convDone(convDone), .singleIrqReq(singleIrqReq), .scanIrqReq(scanIrqReq));

// ==== tb/conv_core_model.sv ====
// analog core model: answers each start after LAT cycles.
// assumes start, abort and power-off come from the sequencer.
`timescale 1ns/10ps
module conv_core_model #(parameter int LAT = 6) (
    input  wire logic        clk,          // clock
    input  wire logic        convStart,    // start pulse
    input  wire logic        convAbort,    // abort pulse
    input  wire logic        convPowerOff, // circuitry off
    input  wire logic        convRes10,    // 10-bit mode
    input  wire logic [3:0]  convChannel,  // sampled channel
    output logic             convDone,     // result pulse
    output logic      [11:0] convData      // result
);
    int          count_q = 0;
    logic [11:0] val_q = 12'h000;
    always @(posedge clk) begin
        if (convAbort || convPowerOff) begin
            count_q <= 0;
        end else if (convStart) begin
            count_q <= LAT;
            val_q <= {convChannel, 4'h5, convChannel} & (convRes10 ? 12'h3FF : 12'hFFF);
        end else if (count_q > 0) begin
            count_q <= count_q - 1;
        end
    end
    assign convDone = (count_q == 1);
    // data line not held outside the done cycle
    assign convData = convDone ? val_q : ~val_q;
endmodule : conv_core_model

// ==== verilog/adc_dual_trigger_sequencer.sv ====
// control logic for a 10/12-bit converter with a software single-channel
// start and a pwm-triggered, delay-gated auto-scan of up to four channels.
// assumes the analog core accepts one start pulse per conversion, stays on
// the selected channel until it answers with a one-cycle done pulse, and
// runs from the clock tick this block makes. pwm trigger inputs are
// synchronous to clk.
//
// Chosen here: strobed register access and the placing of the registers.
`timescale 1ns/10ps

// What this block does
// - software start converts the channel in the single-channel select field
// - auto-scan converts slot channels, count set by scan-count select, max four
// - scan trigger pre-empts a running software conversion, abandoning it
// - pre-empted software conversion sets the result-invalid flag
// - scan entry switches to slot 0 channel then waits trigger delay
// - trigger delay only precedes the first scan channel
// - after each slot go to next; after last return to single channel
// - each slot result lands in its own high and low result registers
// - last scan channel done sets scan-done flag and scan irq request
// - abandoned software conversion never restarts without a new start pulse
// - power-off shuts the converter down and blocks all conversions
// - 12-bit full scale is FFF with 4096 steps; 10-bit has 1024
// - divider codes 000..110 give clk/1..clk/64; 111 undefined, no tick
// - trigger delay equals delay register value times clock period
// - scan trigger from pwm period or a selected pwm duty interrupt
// - busy high during software conversion, cleared at end, single irq raised
module adc_dual_trigger_sequencer (
    input  wire logic        clk,           // 20 MHz system clock
    input  wire logic        sys_rst,       // synchronous reset, active high
    input  wire logic [4:0]  regAddr,       // register word address
    input  wire logic [7:0]  regWrData,     // register write data
    input  wire logic        regWrite,      // write strobe
    input  wire logic        regRead,       // read strobe
    output logic      [7:0]  regRdData,     // read data, cycle after strobe
    input  wire logic        pwmPeriodIrq,  // pwm period event
    input  wire logic [3:0]  pwmDutyIrq,    // pwm duty events
    output logic             convStart,     // start one conversion, pulse
    output logic             convAbort,     // drop the running conversion, pulse
    output logic      [3:0]  convChannel,   // channel routed to the converter
    output logic             convPowerOff,  // converter circuitry shut down
    output logic             convRes10,     // 10-bit resolution when high
    output logic             convClkTick,   // divided converter clock tick
    input  wire logic        convDone,      // conversion finished, pulse
    input  wire logic [11:0] convData,      // conversion result with convDone
    output logic             singleIrqReq,  // single_irq_request level
    output logic             scanIrqReq     // scan_irq_request level
);

    // software-visible control
    logic [7:0]  ctrl0_q;
    logic [7:0]  ctrl1_q;
    logic [7:0]  ctrl2_q;
    logic [7:0]  delay_q;
    logic [7:0]  slotG1_q;
    logic [7:0]  slotG2_q;
    logic        busy_q;
    logic        scanDone_q;
    logic        invalid_q;
    logic        singleIrq_q;
    logic        scanIrq_q;
    logic [7:0]  singleHi_q;
    logic [7:0]  singleLo_q;
    logic [7:0]  scanHi_q [adc_seq_pkg::SLOTS];
    logic [7:0]  scanLo_q [adc_seq_pkg::SLOTS];
    logic [7:0]  rdData_q;

    // sequencer
    adc_seq_pkg::seq_state_type state_q;
    logic [1:0]  slotIdx_q;
    logic [7:0]  delayCnt_q;
    logic        startPrev_q;
    logic        trigPrev_q;
    logic        convStart_q;
    logic        convAbort_q;
    logic [5:0]  divCnt_q;

    // decoded fields
    logic        powerOff;
    logic        fmtRight;
    logic [3:0]  singleChan;
    logic        scanEnable;
    logic        srcDuty;
    logic [2:0]  divCode;
    logic        res10;
    logic [1:0]  dutySel;
    logic [1:0]  lastSlot;
    logic [3:0]  slotChan [adc_seq_pkg::SLOTS];

    // events
    logic        trigLevel;
    logic        scanTrig;
    logic        softStart;
    logic        wrCtrl0;
    logic        wrCtrl2;
    logic        wrIrq;
    logic [15:0] resultWord;

    assign powerOff   = ctrl0_q[adc_seq_pkg::C0_PWROFF];
    assign fmtRight   = ctrl0_q[adc_seq_pkg::C0_FORMAT];
    assign singleChan = ctrl0_q[adc_seq_pkg::C0_CHAN_LO +: 4];
    assign scanEnable = ctrl1_q[adc_seq_pkg::C1_SCAN_EN];
    assign srcDuty    = ctrl1_q[adc_seq_pkg::C1_SRC_SEL];
    assign divCode    = ctrl1_q[adc_seq_pkg::C1_DIV_LO +: 3];
    assign res10      = ctrl2_q[adc_seq_pkg::C2_RES_SEL];
    assign dutySel    = ctrl2_q[adc_seq_pkg::C2_DUTY_LO +: 2];
    assign lastSlot   = ctrl2_q[adc_seq_pkg::C2_CNT_LO +: 2];
    assign slotChan[0] = slotG1_q[3:0];
    assign slotChan[1] = slotG1_q[7:4];
    assign slotChan[2] = slotG2_q[3:0];
    assign slotChan[3] = slotG2_q[7:4];

    assign wrCtrl0 = regWrite && (regAddr == adc_seq_pkg::OFF_CTRL0);
    assign wrCtrl2 = regWrite && (regAddr == adc_seq_pkg::OFF_CTRL2);
    assign wrIrq   = regWrite && (regAddr == adc_seq_pkg::OFF_IRQFLAG);

    // trigger source and edge so a held level fires once
    assign trigLevel = srcDuty ? pwmDutyIrq[dutySel] : pwmPeriodIrq;
    assign scanTrig  = trigLevel && !trigPrev_q && scanEnable && !powerOff
                       && (state_q == adc_seq_pkg::ST_IDLE
                           || state_q == adc_seq_pkg::ST_SOFT_CONV);

    // start fires on the high-to-low return of the start bit
    assign softStart = startPrev_q && !ctrl0_q[adc_seq_pkg::C0_START]
                       && !powerOff && state_q == adc_seq_pkg::ST_IDLE;

    // clip to resolution and align into a high/low byte pair
    function automatic logic [15:0] formatResult(input logic [11:0] data,
                                                 input logic        ten,
                                                 input logic        right);
        logic [11:0] clipped;
        clipped = data & (ten ? adc_seq_pkg::FULL10 : adc_seq_pkg::FULL12);
        if (right) begin
            formatResult = {4'h0, clipped};
        end else if (ten) begin
            formatResult = {clipped[9:0], 6'h00};
        end else begin
            formatResult = {clipped, 4'h0};
        end
    endfunction : formatResult

    assign resultWord = formatResult(convData, res10, fmtRight);

    // outputs
    assign convStart    = convStart_q;
    assign convAbort    = convAbort_q;
    assign convPowerOff = powerOff;
    assign convRes10    = res10;
    assign singleIrqReq = singleIrq_q;
    assign scanIrqReq   = scanIrq_q;
    assign regRdData    = rdData_q;

    // channel routing: slot channel only while scanning
    always_comb begin
        if (state_q == adc_seq_pkg::ST_SCAN_DELAY || state_q == adc_seq_pkg::ST_SCAN_CONV) begin
            convChannel = slotChan[slotIdx_q];
        end else begin
            convChannel = singleChan;
        end
    end

    // converter clock divider, free running while powered
    always_ff @(posedge clk) begin
        if (sys_rst || powerOff) begin
            divCnt_q    <= 6'h00;
            convClkTick <= 1'b0;
        end else begin
            divCnt_q    <= divCnt_q + 6'h01;
            convClkTick <= (divCode != adc_seq_pkg::DIV_UNDEF)
                           && ((divCnt_q & ((6'h01 << divCode) - 6'h01))
                               == ((6'h01 << divCode) - 6'h01));
        end
    end

    // control register writes
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl0_q  <= adc_seq_pkg::RST_CTRL0;
            ctrl1_q  <= adc_seq_pkg::RST_CTRL1;
            ctrl2_q  <= adc_seq_pkg::RST_CTRL2;
            delay_q  <= adc_seq_pkg::RST_DELAY;
            slotG1_q <= adc_seq_pkg::RST_SLOTG;
            slotG2_q <= adc_seq_pkg::RST_SLOTG;
        end else if (regWrite) begin
            unique case (regAddr)
                adc_seq_pkg::OFF_CTRL0:  ctrl0_q  <= regWrData;
                adc_seq_pkg::OFF_CTRL1:  ctrl1_q  <= regWrData;
                adc_seq_pkg::OFF_CTRL2:  ctrl2_q  <= regWrData;
                adc_seq_pkg::OFF_DELAY:  delay_q  <= regWrData;
                adc_seq_pkg::OFF_SLOTG1: slotG1_q <= regWrData;
                adc_seq_pkg::OFF_SLOTG2: slotG2_q <= regWrData;
                default: ;
            endcase
        end
    end

    // edge history for start bit and trigger
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            startPrev_q <= 1'b0;
            trigPrev_q  <= 1'b0;
        end else begin
            startPrev_q <= ctrl0_q[adc_seq_pkg::C0_START];
            trigPrev_q  <= trigLevel;
        end
    end

    // sequencer state machine
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q     <= adc_seq_pkg::ST_IDLE;
            slotIdx_q   <= 2'h0;
            delayCnt_q  <= 8'h00;
            convStart_q <= 1'b0;
            convAbort_q <= 1'b0;
        end else begin
            convStart_q <= 1'b0;
            convAbort_q <= 1'b0;
            if (powerOff && state_q != adc_seq_pkg::ST_IDLE) begin
                state_q     <= adc_seq_pkg::ST_IDLE;
                convAbort_q <= 1'b1;
            end else if (scanTrig) begin
                slotIdx_q   <= 2'h0;
                convAbort_q <= (state_q == adc_seq_pkg::ST_SOFT_CONV);
                if (delay_q == 8'h00) begin
                    state_q     <= adc_seq_pkg::ST_SCAN_CONV;
                    convStart_q <= 1'b1;
                end else begin
                    state_q    <= adc_seq_pkg::ST_SCAN_DELAY;
                    delayCnt_q <= delay_q;
                end
            end else begin
                unique case (state_q)
                    adc_seq_pkg::ST_IDLE: begin
                        if (softStart) begin
                            state_q     <= adc_seq_pkg::ST_SOFT_CONV;
                            convStart_q <= 1'b1;
                        end
                    end
                    adc_seq_pkg::ST_SOFT_CONV: begin
                        if (convDone) begin
                            state_q <= adc_seq_pkg::ST_IDLE;
                        end
                    end
                    adc_seq_pkg::ST_SCAN_DELAY: begin
                        delayCnt_q <= delayCnt_q - 8'h01;
                        if (delayCnt_q == 8'h01) begin
                            state_q     <= adc_seq_pkg::ST_SCAN_CONV;
                            convStart_q <= 1'b1;
                        end
                    end
                    adc_seq_pkg::ST_SCAN_CONV: begin
                        if (convDone) begin
                            if (slotIdx_q == lastSlot) begin
                                state_q <= adc_seq_pkg::ST_IDLE;
                            end else begin
                                slotIdx_q   <= slotIdx_q + 2'h1;
                                convStart_q <= 1'b1;
                            end
                        end
                    end
                endcase
            end
        end
    end

    // busy flag follows a software conversion
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            busy_q <= 1'b0;
        end else if (softStart && !scanTrig) begin
            busy_q <= 1'b1;
        end else if (state_q == adc_seq_pkg::ST_SOFT_CONV
                     && (convDone || scanTrig || powerOff)) begin
            busy_q <= 1'b0;
        end
    end

    // result-invalid: set on pre-emption, cleared by a fresh start
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            invalid_q <= 1'b0;
        end else if (scanTrig && state_q == adc_seq_pkg::ST_SOFT_CONV) begin
            invalid_q <= 1'b1;
        end else if (softStart && !scanTrig) begin
            invalid_q <= 1'b0;
        end
    end

    // scan-done flag: hardware sets, software writes zero to clear, set wins
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            scanDone_q <= 1'b0;
        end else if (state_q == adc_seq_pkg::ST_SCAN_CONV && convDone
                     && slotIdx_q == lastSlot && !powerOff) begin
            scanDone_q <= 1'b1;
        end else if (wrCtrl2 && !regWrData[adc_seq_pkg::C2_DONE]) begin
            scanDone_q <= 1'b0;
        end
    end

    // interrupt request flags, cleared by writing zero, set wins
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            singleIrq_q <= 1'b0;
            scanIrq_q   <= 1'b0;
        end else begin
            if (state_q == adc_seq_pkg::ST_SOFT_CONV && convDone
                && !scanTrig && !powerOff) begin
                singleIrq_q <= 1'b1;
            end else if (wrIrq && !regWrData[adc_seq_pkg::IRQ_SINGLE]) begin
                singleIrq_q <= 1'b0;
            end
            if (state_q == adc_seq_pkg::ST_SCAN_CONV && convDone
                && slotIdx_q == lastSlot && !powerOff) begin
                scanIrq_q <= 1'b1;
            end else if (wrIrq && !regWrData[adc_seq_pkg::IRQ_SCAN]) begin
                scanIrq_q <= 1'b0;
            end
        end
    end

    // result capture
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            singleHi_q <= 8'h00;
            singleLo_q <= 8'h00;
            for (int i = 0; i < adc_seq_pkg::SLOTS; i++) begin
                scanHi_q[i] <= 8'h00;
                scanLo_q[i] <= 8'h00;
            end
        end else if (convDone && !powerOff && !scanTrig) begin
            if (state_q == adc_seq_pkg::ST_SOFT_CONV) begin
                singleHi_q <= resultWord[15:8];
                singleLo_q <= resultWord[7:0];
            end else if (state_q == adc_seq_pkg::ST_SCAN_CONV) begin
                scanHi_q[slotIdx_q] <= resultWord[15:8];
                scanLo_q[slotIdx_q] <= resultWord[7:0];
            end
        end
    end

    // read port, data stands the cycle after the strobe
    always_ff @(posedge clk) begin
        if (sys_rst || !regRead) begin
            rdData_q <= 8'h00;
        end else begin
            unique case (regAddr)
                adc_seq_pkg::OFF_CTRL0: begin
                    rdData_q <= ctrl0_q;
                    rdData_q[adc_seq_pkg::C0_BUSY] <= busy_q;
                end
                adc_seq_pkg::OFF_CTRL1: rdData_q <= ctrl1_q;
                adc_seq_pkg::OFF_CTRL2: begin
                    rdData_q <= ctrl2_q;
                    rdData_q[adc_seq_pkg::C2_DONE]    <= scanDone_q;
                    rdData_q[adc_seq_pkg::C2_INVALID] <= invalid_q;
                end
                adc_seq_pkg::OFF_DELAY:   rdData_q <= delay_q;
                adc_seq_pkg::OFF_SLOTG1:  rdData_q <= slotG1_q;
                adc_seq_pkg::OFF_SLOTG2:  rdData_q <= slotG2_q;
                adc_seq_pkg::OFF_IRQFLAG: rdData_q <= {6'h00, scanIrq_q, singleIrq_q};
                adc_seq_pkg::OFF_SRES_HI: rdData_q <= singleHi_q;
                adc_seq_pkg::OFF_SRES_LO: rdData_q <= singleLo_q;
                5'h09:   rdData_q <= scanHi_q[0];
                5'h0A:   rdData_q <= scanLo_q[0];
                5'h0B:   rdData_q <= scanHi_q[1];
                5'h0C:   rdData_q <= scanLo_q[1];
                5'h0D:   rdData_q <= scanHi_q[2];
                5'h0E:   rdData_q <= scanLo_q[2];
                5'h0F:   rdData_q <= scanHi_q[3];
                5'h10:   rdData_q <= scanLo_q[3];
                default: rdData_q <= 8'h00;
            endcase
        end
    end

endmodule : adc_dual_trigger_sequencer
